// [core/sps_pkg.sv]
// Purpose: shared constants for the serial programming port (programmer end and device end)
// Assumes: 10 MHz system clock; the link clock is the programmer's serial clock
// Notes: opcodes are first and second instruction bytes, sent msb first
//
// Functional notes
// - programming only while reset pin is low
// - enable instruction required before any program/erase
// - eeprom byte write overwrites with built-in erase
// - chip erase sets flash and eeprom to ff
// - programmer holds each clock phase over two cycles
// - capture on rising edge, shift out on falling
// - power-up: reset and clock low, else pulse reset
// - programmer waits 20 ms before enable instruction
// - enable second byte echoes during third byte
// - always four bytes; no echo means reset and retry
// - page buffer by 6 lsb, low before high
// - page write commits buffer; 2.6 ms without polling
// - eeprom byte write; 3.6 ms without polling
// - eeprom page write changes loaded bytes only
// - read returns addressed content in fourth byte
// - poll status lsb is 1 while write pending
// - flash reads word addressed, high and low opcodes
// - fuse/lock read 0 programmed; write selectors
// - extended fuse read returns fuse byte fourth
// - programmer waits after erase and fuse writes
// - reset pin high ends programming mode
// - programmer writes unused fuse bits as one
// - lock bits cleared only by chip erase
package sps_pkg;
    // ****************************************
    // instruction bytes
    // ****************************************
    localparam logic [7:0] OP_ACCESS = 8'hac;
    localparam logic [7:0] B2_PROG_EN = 8'h53;
    localparam logic [7:0] B2_ERASE = 8'h80;
    localparam logic [7:0] B2_WR_LOCK = 8'he0;
    localparam logic [7:0] B2_WR_FUSE_L = 8'ha0;
    localparam logic [7:0] B2_WR_FUSE_H = 8'ha8;
    localparam logic [7:0] B2_WR_FUSE_X = 8'ha4;
    localparam logic [7:0] B2_HIGH_SEL = 8'h08;
    localparam logic [7:0] OP_POLL = 8'hf0;
    localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_LOAD_EE = 8'hc1;
    localparam logic [7:0] OP_RD_HI = 8'h28;
    localparam logic [7:0] OP_RD_LO = 8'h20;
    localparam logic [7:0] OP_RD_EE = 8'ha0;
    localparam logic [7:0] OP_RD_LOCK = 8'h58;
    localparam logic [7:0] OP_RD_SIG = 8'h30;
    localparam logic [7:0] OP_RD_FUSE = 8'h50;
    localparam logic [7:0] OP_RD_CAL = 8'h38;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_WR_EE = 8'hc0;
    localparam logic [7:0] OP_WR_EE_PAGE = 8'hc2;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // ****************************************
    // geometry
    // ****************************************
    localparam int FL_AW_DEF = 13;
    localparam int PAGE_AW_DEF = 6;
    localparam int EE_AW_DEF = 10;
    localparam int EE_PAGE_AW = 2;
    // ****************************************
    // self-timed write kinds
    // ****************************************
    localparam logic [1:0] WK_FLASH = 2'h0;
    localparam logic [1:0] WK_EEPROM = 2'h1;
    localparam logic [1:0] WK_ERASE = 2'h2;
    localparam logic [1:0] WK_FUSE = 2'h3;
    // ****************************************
    // timing
    // ****************************************
    localparam real CLK_PERIOD_NS = 100.0;
    localparam real FLASH_PAGE_WAIT_MS = 2.6;
    localparam real EEPROM_WRITE_WAIT_MS = 3.6;
    localparam real CHIP_ERASE_WAIT_MS = 10.5;
    localparam real FUSE_WRITE_WAIT_MS = 4.5;
    localparam real POWERUP_WAIT_MS = 20.0;
    // device finishes inside the programmer's blind wait, so round down
    localparam int FLASH_PAGE_WAIT_CYC = int'($floor(FLASH_PAGE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int EEPROM_WRITE_WAIT_CYC = int'($floor(EEPROM_WRITE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int CHIP_ERASE_WAIT_CYC = int'($floor(CHIP_ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int FUSE_WRITE_WAIT_CYC = int'($floor(FUSE_WRITE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int POWERUP_WAIT_CYC = int'($ceil(POWERUP_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int SCK_PHASE_OVER_CYC = 2;
    localparam int SCK_HALF_DEF = SCK_PHASE_OVER_CYC + 2;
    localparam int RST_PULSE_CYC = 2;
endpackage : sps_pkg

// [core/sps_if.sv]
// Purpose: serial programming link between programmer and device
// Assumes: programmer is the only driver of reset pin, clock and data in
// Notes: miso is driven only by the device
`timescale 1ns/1ps
interface sps_if;
    logic prog_rst_n; // reset pin, low holds device in programming
    logic sck;        // serial clock from programmer
    logic mosi;       // data to device
    logic miso;       // data from device
    modport dev (input prog_rst_n, input sck, input mosi, output miso);
    modport prog (output prog_rst_n, output sck, output mosi, input miso);
endinterface : sps_if

// [core/sps_dev_end.sv]
// Purpose: device end of the serial programming port with flash, eeprom, fuses and lock bits
// Assumes: link logic runs on sck; write timing runs on clk
// Notes: writes are refused while a self-timed write is pending
`timescale 1ns/1ps
module sps_dev_end import sps_pkg::*; #(
    parameter int FL_AW = FL_AW_DEF,
    parameter int PAGE_AW = PAGE_AW_DEF,
    parameter int EE_AW = EE_AW_DEF,
    parameter int FLASH_WAIT = FLASH_PAGE_WAIT_CYC,
    parameter int EEPROM_WAIT = EEPROM_WRITE_WAIT_CYC,
    parameter int ERASE_WAIT = CHIP_ERASE_WAIT_CYC,
    parameter int FUSE_WAIT = FUSE_WRITE_WAIT_CYC,
    parameter logic [7:0] SIG_0 = 8'h11, // arbitrary value
    parameter logic [7:0] SIG_1 = 8'h22, // arbitrary value
    parameter logic [7:0] SIG_2 = 8'h33, // arbitrary value
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic clk,        // system clock
    input wire logic rst,        // synchronous reset
    sps_if.dev link,             // programming link
    output logic run_mode,       // reset pin released, normal operation
    output logic prog_enabled    // programming enable accepted
);
    if (PAGE_AW < 1 || PAGE_AW > 8 || FL_AW <= PAGE_AW || FL_AW > 16 || EE_AW < 3 || EE_AW > 10)
    begin : g_geom_chk
        $error("sps_dev_end: unsupported memory geometry");
    end
    if (FLASH_WAIT < 1 || EEPROM_WAIT < 1 || ERASE_WAIT < 1 || FUSE_WAIT < 1) begin : g_wait_chk
        $error("sps_dev_end: wait counts must be at least one");
    end

    // ****************************************
    // link domain state
    // ****************************************
    logic [30:0] rx_reg;
    logic [4:0] cnt_reg;
    logic [7:0] tx_reg;
    logic miso_reg;
    logic en_reg;
    logic start_tog_reg;
    logic [1:0] kind_reg;
    logic done_s1_reg;
    logic done_s2_reg;
    logic done_tog_reg;
    logic [(1<<EE_PAGE_AW)-1:0] ee_loaded_reg;
    logic [15:0] flash_mem [0:(1<<FL_AW)-1];
    logic [15:0] pbuf_mem [0:(1<<PAGE_AW)-1];
    logic [7:0] ee_mem [0:(1<<EE_AW)-1];
    logic [7:0] ee_buf_mem [0:(1<<EE_PAGE_AW)-1];
    logic [7:0] lock_reg;
    logic [7:0] fuse_l_reg;
    logic [7:0] fuse_h_reg;
    logic [7:0] fuse_x_reg;
    logic [31:0] word;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [FL_AW-1:0] fl_a;
    logic [EE_AW-1:0] ee_a;
    logic busy;
    logic exec;
    logic wr_ok;

    assign word = {rx_reg, link.mosi};
    assign b1 = word[31:24];
    assign b2 = word[23:16];
    assign b3 = word[15:8];
    assign b4 = word[7:0];
    assign fl_a = FL_AW'({b2, b3});
    assign ee_a = EE_AW'({b2, b3});
    assign busy = start_tog_reg ^ done_s2_reg;
    assign exec = (cnt_reg == 5'h1f) && en_reg;
    assign wr_ok = exec && !busy;
    assign link.miso = miso_reg;

    // answer for bytes 1..3 seen so far; unknown instructions just echo
    function automatic logic [7:0] rd_resp(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
        logic [FL_AW-1:0] fa;
        logic [EE_AW-1:0] ea;
        fa = FL_AW'({c2, c3});
        ea = EE_AW'({c2, c3});
        case (c1)
            OP_POLL: rd_resp = {7'h00, busy};
            OP_RD_HI: rd_resp = flash_mem[fa][15:8];
            OP_RD_LO: rd_resp = flash_mem[fa][7:0];
            OP_RD_EE: rd_resp = ee_mem[ea];
            OP_RD_LOCK: rd_resp = (c2 == B2_HIGH_SEL) ? fuse_h_reg : lock_reg;
            OP_RD_FUSE: rd_resp = (c2 == B2_HIGH_SEL) ? fuse_x_reg : fuse_l_reg;
            OP_RD_CAL: rd_resp = CAL_BYTE;
            OP_RD_SIG: begin
                case (c3[1:0])
                    2'h0: rd_resp = SIG_0;
                    2'h1: rd_resp = SIG_1;
                    2'h2: rd_resp = SIG_2;
                    default: rd_resp = ERASED_BYTE;
                endcase
            end
            default: rd_resp = c3;
        endcase
    endfunction : rd_resp

    // ****************************************
    // shifter: in on rising, out on falling
    // ****************************************
    always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
        if (link.prog_rst_n) begin
            rx_reg <= '0;
            cnt_reg <= '0;
            tx_reg <= '0;
        end else begin
            rx_reg <= word[30:0];
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == 5'h17) begin
                tx_reg <= en_reg ? rd_resp(word[23:16], word[15:8], word[7:0]) : word[7:0];
            end else if (cnt_reg[2:0] == 3'h7) begin
                tx_reg <= word[7:0];
            end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end

    always_ff @(negedge link.sck or posedge link.prog_rst_n) begin
        if (link.prog_rst_n) begin
            miso_reg <= 1'b0;
        end else begin
            miso_reg <= tx_reg[7];
        end
    end

    always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
        if (link.prog_rst_n) begin
            en_reg <= 1'b0;
        end else if (cnt_reg == 5'h1f && b1 == OP_ACCESS && b2 == B2_PROG_EN) begin
            en_reg <= 1'b1;
        end
    end

    // ****************************************
    // start of self-timed writes
    // ****************************************
    always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
        if (link.prog_rst_n) begin
            start_tog_reg <= 1'b0;
            kind_reg <= WK_FLASH;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
        end else begin
            done_s1_reg <= done_tog_reg;
            done_s2_reg <= done_s1_reg;
            if (wr_ok && (b1 == OP_WR_PAGE || b1 == OP_WR_EE || b1 == OP_WR_EE_PAGE ||
                          (b1 == OP_ACCESS && b2 != B2_PROG_EN))) begin
                start_tog_reg <= ~start_tog_reg;
                if (b1 == OP_WR_PAGE) begin
                    kind_reg <= WK_FLASH;
                end else if (b1 != OP_ACCESS) begin
                    kind_reg <= WK_EEPROM;
                end else if (b2 == B2_ERASE) begin
                    kind_reg <= WK_ERASE;
                end else begin
                    kind_reg <= WK_FUSE;
                end
            end
        end
    end

    // eeprom page buffer marks do not survive a session restart
    always_ff @(posedge link.sck or posedge link.prog_rst_n) begin
        if (link.prog_rst_n) begin
            ee_loaded_reg <= '0;
        end else if (exec && b1 == OP_LOAD_EE) begin
            ee_loaded_reg[b3[EE_PAGE_AW-1:0]] <= 1'b1;
        end else if (wr_ok && b1 == OP_WR_EE_PAGE) begin
            ee_loaded_reg <= '0;
        end
    end

    // ****************************************
    // nonvolatile arrays and page buffers, no reset by design
    // ****************************************
    always_ff @(posedge link.sck) begin
        if (exec && b1 == OP_LOAD_LO) begin
            pbuf_mem[b3[PAGE_AW-1:0]][7:0] <= b4;
        end
        if (exec && b1 == OP_LOAD_HI) begin
            pbuf_mem[b3[PAGE_AW-1:0]][15:8] <= b4;
        end
        if (exec && b1 == OP_LOAD_EE) begin
            ee_buf_mem[b3[EE_PAGE_AW-1:0]] <= b4;
        end
        if (wr_ok) begin
            case (b1)
                OP_WR_PAGE: begin
                    for (int i = 0; i < (1 << PAGE_AW); i++) begin
                        flash_mem[{fl_a[FL_AW-1:PAGE_AW], PAGE_AW'(i)}] <= pbuf_mem[i];
                    end
                end
                OP_WR_EE: ee_mem[ee_a] <= b4;
                OP_WR_EE_PAGE: begin
                    for (int j = 0; j < (1 << EE_PAGE_AW); j++) begin
                        if (ee_loaded_reg[j]) begin
                            ee_mem[{ee_a[EE_AW-1:EE_PAGE_AW], EE_PAGE_AW'(j)}] <= ee_buf_mem[j];
                        end
                    end
                end
                OP_ACCESS: begin
                    case (b2)
                        B2_ERASE: begin
                            for (int k = 0; k < (1 << FL_AW); k++) begin
                                flash_mem[k] <= ERASED_WORD;
                            end
                            for (int k = 0; k < (1 << EE_AW); k++) begin
                                ee_mem[k] <= ERASED_BYTE;
                            end
                            lock_reg <= ERASED_BYTE;
                        end
                        B2_WR_LOCK: lock_reg <= lock_reg & b4;
                        B2_WR_FUSE_L: fuse_l_reg <= b4;
                        B2_WR_FUSE_H: fuse_h_reg <= b4;
                        B2_WR_FUSE_X: fuse_x_reg <= b4;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // ****************************************
    // system clock domain: write timer, status
    // ****************************************
    logic start_s1_reg;
    logic start_s2_reg;
    logic start_s3_reg;
    logic [1:0] kind_s1_reg;
    logic [1:0] kind_s2_reg;
    logic pin_s1_reg;
    logic en_s1_reg;
    logic wait_act_reg;
    logic [31:0] wait_cnt_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            start_s1_reg <= 1'b0;
            start_s2_reg <= 1'b0;
            start_s3_reg <= 1'b0;
            kind_s1_reg <= WK_FLASH;
            kind_s2_reg <= WK_FLASH;
            pin_s1_reg <= 1'b1;
            run_mode <= 1'b1;
            en_s1_reg <= 1'b0;
            prog_enabled <= 1'b0;
        end else begin
            start_s1_reg <= start_tog_reg;
            start_s2_reg <= start_s1_reg;
            start_s3_reg <= start_s2_reg;
            kind_s1_reg <= kind_reg;
            kind_s2_reg <= kind_s1_reg;
            pin_s1_reg <= link.prog_rst_n;
            run_mode <= pin_s1_reg;
            en_s1_reg <= en_reg;
            prog_enabled <= en_s1_reg;
        end
    end

    // kind is stable a full cycle before start_s3 moves, so it is safe to take here
    always_ff @(posedge clk) begin
        if (rst) begin
            done_tog_reg <= 1'b0;
            wait_act_reg <= 1'b0;
            wait_cnt_reg <= '0;
        end else if (!wait_act_reg && start_s3_reg != done_tog_reg) begin
            wait_act_reg <= 1'b1;
            unique case (kind_s2_reg)
                WK_FLASH: wait_cnt_reg <= 32'(FLASH_WAIT);
                WK_EEPROM: wait_cnt_reg <= 32'(EEPROM_WAIT);
                WK_ERASE: wait_cnt_reg <= 32'(ERASE_WAIT);
                WK_FUSE: wait_cnt_reg <= 32'(FUSE_WAIT);
            endcase
        end else if (wait_act_reg) begin
            if (wait_cnt_reg <= 32'h1) begin
                wait_act_reg <= 1'b0;
                done_tog_reg <= start_s3_reg;
            end else begin
                wait_cnt_reg <= wait_cnt_reg - 32'h1;
            end
        end
    end
endmodule : sps_dev_end

// [core/sps_prog_end.sv]
// Purpose: programmer end: drives reset pin and divided serial clock, runs 32-bit instructions
// Assumes: user issues the enable instruction first and polls or waits after writes
// Notes: dropping session_en holds the reset pin high until session_en returns, which resynchronises the link
`timescale 1ns/1ps
module sps_prog_end import sps_pkg::*; #(
    parameter int SCK_HALF = SCK_HALF_DEF,
    parameter int POWERUP_CYC = POWERUP_WAIT_CYC
) (
    input wire logic clk,               // system clock
    input wire logic rst,               // synchronous reset
    sps_if.prog link,                   // programming link
    input wire logic session_en,        // level: hold device in programming
    output logic link_ready,            // settle wait over
    input wire logic cmd_valid,         // instruction offered
    input wire logic [31:0] cmd_word,   // instruction, byte 1 in bits 31:24
    output logic cmd_ready,             // instruction may be taken
    output logic resp_valid,            // pulse: instruction finished
    output logic [31:0] resp_word       // all bits read back on miso
);
    if (SCK_HALF < SCK_PHASE_OVER_CYC + 1 || POWERUP_CYC < 1) begin : g_chk
        $error("sps_prog_end: clock phase or settle count too small");
    end

    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_IDLE = 4'b0100,
        ST_SHIFT = 4'b1000
    } sps_state_e;

    sps_state_e state_reg;
    logic [31:0] cnt_reg;
    logic [31:0] tx_reg;
    logic [31:0] rx_reg;
    logic [4:0] bit_reg;
    logic rst_pin_reg;
    logic sck_reg;
    logic mosi_reg;
    logic miso_s1_reg;
    logic miso_s2_reg;

    assign link.prog_rst_n = rst_pin_reg;
    assign link.sck = sck_reg;
    assign link.mosi = mosi_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            miso_s1_reg <= 1'b0;
            miso_s2_reg <= 1'b0;
        end else begin
            miso_s1_reg <= link.miso;
            miso_s2_reg <= miso_s1_reg;
        end
    end

    // ****************************************
    // session and shift sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_OFF;
            cnt_reg <= '0;
            tx_reg <= '0;
            rx_reg <= '0;
            bit_reg <= '0;
            rst_pin_reg <= 1'b1;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            link_ready <= 1'b0;
            cmd_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_word <= '0;
        end else if (!session_en && state_reg != ST_OFF) begin
            state_reg <= ST_OFF;
            cnt_reg <= '0;
            rst_pin_reg <= 1'b1;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            link_ready <= 1'b0;
            cmd_ready <= 1'b0;
            resp_valid <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            unique case (state_reg)
                ST_OFF: begin
                    // reset stays high with sck low for the pulse time before entry
                    if (cnt_reg < 32'(RST_PULSE_CYC)) begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end else if (session_en) begin
                        rst_pin_reg <= 1'b0;
                        cnt_reg <= '0;
                        state_reg <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (cnt_reg >= 32'(POWERUP_CYC - 1)) begin
                        state_reg <= ST_IDLE;
                        link_ready <= 1'b1;
                        cmd_ready <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                ST_IDLE: begin
                    if (cmd_valid) begin
                        tx_reg <= {cmd_word[30:0], 1'b0};
                        mosi_reg <= cmd_word[31];
                        bit_reg <= '0;
                        cnt_reg <= '0;
                        cmd_ready <= 1'b0;
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (cnt_reg < 32'(SCK_HALF - 1)) begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end else begin
                        cnt_reg <= '0;
                        sck_reg <= ~sck_reg;
                        if (!sck_reg) begin
                            rx_reg <= {rx_reg[30:0], miso_s2_reg};
                        end else if (bit_reg == 5'h1f) begin
                            state_reg <= ST_IDLE;
                            resp_valid <= 1'b1;
                            resp_word <= rx_reg;
                            cmd_ready <= 1'b1;
                        end else begin
                            mosi_reg <= tx_reg[31];
                            tx_reg <= {tx_reg[30:0], 1'b0};
                            bit_reg <= bit_reg + 5'h01;
                        end
                    end
                end
            endcase
        end
    end
endmodule : sps_prog_end

// [tb/sps_link_sva.sv]
// Purpose: link checks between programmer end and device end
// Assumes: sck is divided from clk, so clk samples every phase
// Notes: no clock-domain crossing is needed for these checks
`timescale 1ns/1ps
module sps_link_sva (
    input wire logic clk, // system clock
    input wire logic rst, // sync reset
    input wire logic prog_rst_n, // reset pin
    input wire logic sck, // serial clock
    input wire logic mosi, // data to device
    input wire logic miso // data from device
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_hi; $rose(sck) |-> sck[*3]; endproperty
    a_hi: assert property (p_hi) else $error("sck high phase short");
    property p_lo; $fell(sck) |-> !sck[*3]; endproperty
    a_lo: assert property (p_lo) else $error("sck low phase short");
    property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("mosi moved while sck high");
    property p_miso; sck && $past(sck) |-> $stable(miso); endproperty
    a_miso: assert property (p_miso) else $error("miso moved while sck high");
    property p_pin_off; prog_rst_n |-> !sck; endproperty
    a_pin_off: assert property (p_pin_off) else $error("sck active outside session");
    property p_miso_off; prog_rst_n && $past(prog_rst_n) |-> !miso; endproperty
    a_miso_off: assert property (p_miso_off) else $error("miso driven outside session");
    property p_pulse; $rose(prog_rst_n) |-> prog_rst_n[*2]; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pin pulse short");
    property p_enter; $fell(prog_rst_n) |-> !sck[*8]; endproperty
    a_enter: assert property (p_enter) else $error("sck toggled before settle");
endmodule : sps_link_sva

// [tb/tb.sv]
// Purpose: both ends joined; user side driven, memories read back
// Assumes: shortened write waits so the first poll still sees busy
// Notes: random addresses and data from a fixed seed
`timescale 1ns/1ps
module tb import sps_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic session_en = 1'b0;
    logic cmd_valid = 1'b0;
    logic [31:0] cmd_word = 32'h0;
    logic link_ready, cmd_ready, resp_valid, run_mode, prog_enabled;
    logic [31:0] resp_word, r;
    logic [7:0] a, d, f;
    logic [7:0] wsel [3] = '{B2_WR_FUSE_L, B2_WR_FUSE_H, B2_WR_FUSE_X};
    logic [15:0] rsel [3] = '{16'h5000, 16'h5808, 16'h5008};
    int error_cnt = 0;
    int compares = 0;
    always #50 clk = ~clk;
    sps_if link_if();
    sps_prog_end #(.POWERUP_CYC(50)) sps_prog_end_inst (.clk(clk), .rst(rst), .link(link_if.prog),
        .session_en(session_en), .link_ready(link_ready), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_word(resp_word));
    sps_dev_end #(.FLASH_WAIT(900), .EEPROM_WAIT(900), .ERASE_WAIT(900), .FUSE_WAIT(900))
        sps_dev_end_inst (.clk(clk), .rst(rst), .link(link_if.dev),
        .run_mode(run_mode), .prog_enabled(prog_enabled));
    sps_link_sva sps_link_sva_inst (.clk(clk), .rst(rst), .prog_rst_n(link_if.prog_rst_n),
        .sck(link_if.sck), .mosi(link_if.mosi), .miso(link_if.miso));
    task automatic end_of_test();
        if (error_cnt == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic xfer(input logic [31:0] w);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_word <= w;
        do @(negedge clk); while (cmd_ready !== 1'b1);
        @(posedge clk);
        cmd_valid <= 1'b0;
        do @(negedge clk); while (resp_valid !== 1'b1);
        r = resp_word;
    endtask : xfer
    task automatic rd(input string nm, input logic [31:0] w, input logic [7:0] e);
        xfer(w);
        chk(nm, e, r[7:0]);
    endtask : rd
    // first poll must still see the write pending, later ones wait for it to end
    task automatic poll();
        xfer(32'hf0000000);
        chk("busy", 8'h01, {7'h0, r[0]});
        repeat (20) if (r[0] === 1'b1) xfer(32'hf0000000);
        chk("done", 8'h00, {7'h0, r[0]});
    endtask : poll
    task automatic open_session();
        @(posedge clk);
        session_en <= 1'b1;
        repeat (4) @(negedge clk);
        do @(negedge clk); while (link_ready !== 1'b1);
    endtask : open_session
    initial begin
        void'($urandom(79078));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        open_session();
        chk("enabled", 8'h00, {7'h0, prog_enabled});
        chk("run", 8'h00, {7'h0, run_mode});
        xfer({OP_ACCESS, B2_PROG_EN, 16'h0});
        chk("echo", B2_PROG_EN, r[15:8]);
        chk("enabled", 8'h01, {7'h0, prog_enabled});
        a = 8'($urandom());
        d = 8'($urandom());
        xfer({OP_ACCESS, B2_ERASE, 16'h0});
        xfer({OP_WR_EE, 8'h0, a, 8'h5a});
        poll();
        rd("flash", {OP_RD_HI, 8'h0, a, 8'h0}, ERASED_BYTE);
        rd("eeprom", {OP_RD_EE, 8'h0, a, 8'h0}, ERASED_BYTE);
        for (int k = 0; k < 2; k++) begin
            f = k ? ~d : d;
            xfer({OP_WR_EE, 8'h0, a, f});
            poll();
            rd("eeprom", {OP_RD_EE, 8'h0, a, 8'h0}, f);
        end
        xfer({OP_LOAD_LO, 8'h0, 2'h0, a[5:0], d});
        xfer({OP_LOAD_HI, 8'h0, 2'h0, a[5:0], ~d});
        xfer({OP_WR_PAGE, 8'h0, a[7:6], 6'h0, 8'h0});
        poll();
        rd("flash lo", {OP_RD_LO, 8'h0, a, 8'h0}, d);
        rd("flash hi", {OP_RD_HI, 8'h0, a, 8'h0}, ~d);
        xfer({OP_LOAD_EE, 8'h0, 6'h0, a[1:0], d});
        xfer({OP_WR_EE_PAGE, 8'h0, a[7:2], 2'h0, 8'h0});
        poll();
        rd("ee page", {OP_RD_EE, 8'h0, a, 8'h0}, d);
        rd("ee keep", {OP_RD_EE, 8'h0, a ^ 8'h01, 8'h0}, ERASED_BYTE);
        for (int k = 0; k < 3; k++) begin
            f = 8'($urandom());
            xfer({OP_ACCESS, wsel[k], 8'h0, f});
            poll();
            rd("fuse", {rsel[k], 16'h0}, f);
        end
        for (int k = 0; k < 2; k++) begin
            xfer({OP_ACCESS, B2_WR_LOCK, 8'h0, k ? ERASED_BYTE : f});
            poll();
            rd("lock", {OP_RD_LOCK, 24'h0}, f);
        end
        xfer({OP_ACCESS, B2_ERASE, 16'h0});
        poll();
        rd("lock", {OP_RD_LOCK, 24'h0}, ERASED_BYTE);
        @(posedge clk);
        session_en <= 1'b0;
        repeat (20) @(negedge clk);
        chk("run", 8'h01, {7'h0, run_mode});
        open_session();
        xfer({OP_ACCESS, B2_WR_LOCK, 16'h0});
        xfer({OP_ACCESS, B2_PROG_EN, 16'h0});
        rd("lock", {OP_RD_LOCK, 24'h0}, ERASED_BYTE);
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule : tb
